// *** include/loopback_defines.svh ***
// Constants for the transceiver loopback selection block.
// Assumes a 50 MHz system clock and an APB register port with byte offsets.
// Function
// - Framer loop in T1 sends unframed ones.
// - Framer loop: receive fed from transmit.
// - Payload loop: transmit timed by receive clock.
// - Payload loop leaves receive side normal.
// - Payload loop holds channel clock, block low.
// - Payload loop ignores serial, insert, signaling.
// - T1 payload: 192 bits, framing regenerated.
// - E1 payload: 248 bits, overhead regenerated.
// - Remote loop returns line receive data, or framer-side pins if separated.
// - Local loop replaces receive with transmit.
// - Select bit sets shared pin role.
// - Connect table for line unit, framer.
// - Enabled channels take receive channel data.
// - Enable bits map channels one to 32.
// - Any channel subset may be looped.
`ifndef LOOPBACK_DEFINES_SVH
`define LOOPBACK_DEFINES_SVH
// Register indexes; each register is one word, so its byte address is four times its index.
`define IDX_LOOP_CTRL 10'h04A
`define IDX_CH_EN_1 10'h04B
`define IDX_CH_EN_2 10'h04C
`define IDX_CH_EN_3 10'h04D
`define IDX_CH_EN_4 10'h04E
`define IDX_MODE 10'h04F
`define IDX_STATUS 10'h050
`define ADDR_LOOP_CTRL {`IDX_LOOP_CTRL, 2'b00}
`define ADDR_CH_EN_1 {`IDX_CH_EN_1, 2'b00}
`define ADDR_CH_EN_2 {`IDX_CH_EN_2, 2'b00}
`define ADDR_CH_EN_3 {`IDX_CH_EN_3, 2'b00}
`define ADDR_CH_EN_4 {`IDX_CH_EN_4, 2'b00}
`define ADDR_MODE {`IDX_MODE, 2'b00}
`define ADDR_STATUS {`IDX_STATUS, 2'b00}
`define BIT_FRAMER_LOOP 0
`define BIT_PAYLOAD_LOOP 1
`define BIT_REMOTE_LOOP 2
`define BIT_LOCAL_LOOP 3
`define BIT_MUX 4
`define BIT_PIN_SEL 7
`define CTRL_WMASK 8'h9F
`define RESET_BYTE 8'h00
`define BITS_PER_SLOT 4'h8
`define T1_PAYLOAD_BITS 9'h0C0
`define E1_PAYLOAD_BITS 9'h0F8
`define T1_FRAME_BITS 9'h0C1
`define E1_FRAME_BITS 9'h100
`endif

// *** include/loopback_pkg.sv ***
// Types shared by the loopback selection block.
// Assumes nothing beyond the defines header.
package loopback_pkg;
  typedef enum logic [1:0]
  {
    TX_NORMAL = 2'b00,
    TX_PAYLOAD = 2'b01,
    TX_REMOTE = 2'b10,
    TX_ONES = 2'b11
  } tx_src_t;
endpackage

// *** design/bit_fifo.sv ***
// Small valid/ready FIFO used on the looped receive bit path.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
module bit_fifo
#(
  parameter int WIDTH = 3,
  parameter int DEPTH = 4
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Fill side.
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side.
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_ready = (cnt_q != DEPTH[AW:0]);
  assign o_valid = (cnt_q != '0);
  assign o_data = mem[rd_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// *** design/edge_sync.sv ***
// Two-flop synchroniser with rising-edge detect for an outside level.
// Assumes the input is asynchronous to the system clock.
`timescale 1ns/1ps
module edge_sync
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Asynchronous level in.
  input wire logic i_async,
  // Synchronised level and edges.
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q && !prev_q;
  assign o_fall = !sync_q && prev_q;
endmodule

// *** design/loopback_ctrl.sv ***
// Loopback selection for one T1/E1 transceiver, with APB registers.
// Assumes line and backplane signals are slow pins sampled on I_CLK_SYS.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "loopback_defines.svh"
module loopback_ctrl
  import loopback_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
)
(
  // System clock and reset.
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Mode straps and shared pin.
  input wire logic I_E1_MODE,
  input wire logic I_MUX_OR_POWERDOWN_PIN,
  // Line receive pins and clock.
  input wire logic I_RX_LINE_POS_IN,
  input wire logic I_RX_LINE_NEG_IN,
  input wire logic I_RX_CLOCK_IN,
  input wire logic I_RX_FRAME_SYNC,
  // External framer-side pins.
  input wire logic I_FRAMER_TX_POS_IN,
  input wire logic I_FRAMER_TX_NEG_IN,
  input wire logic I_FRAMER_TX_CLOCK_IN,
  // Transmit clock, sync and backplane.
  input wire logic I_TX_CLOCK,
  input wire logic I_TX_FRAME_SYNC,
  input wire logic I_TX_SERIAL_IN,
  input wire logic I_TX_INSERT_IN,
  input wire logic I_TX_SIGNALING_IN,
  // Formatter bipolar output and receive framer data.
  input wire logic I_FMT_POS,
  input wire logic I_FMT_NEG,
  input wire logic I_RX_FRAMER_DATA,
  // Line transmit pins and framer-side receive path.
  output logic O_TX_LINE_POS_OUT,
  output logic O_TX_LINE_NEG_OUT,
  output logic O_RX_POS,
  output logic O_RX_NEG,
  output logic O_RX_TIMING_TICK,
  output logic O_RX_JITTER_ATTEN_PATH,
  // Transmit side outputs.
  output logic O_TX_TIMING_TICK,
  output logic O_TX_LINK_CLOCK,
  output logic O_TX_CHANNEL_CLOCK,
  output logic O_TX_CHANNEL_BLOCK,
  output logic O_TX_SERIAL_TO_FMT,
  output logic O_TX_INSERT_TO_FMT,
  output logic O_TX_SIGNALING_TO_FMT,
  output logic O_REGEN_OVERHEAD,
  output logic O_TX_POWERDOWN,
  output logic O_LINE_UNIT_CONNECTED
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic rx_clk_s, rx_clk_rise, tx_clk_s, tx_clk_rise;
  logic rxp_s, rxn_s, ftp_s, ftn_s, ftc_rise;
  logic txs_s, rxs_s, ser_s, ins_s, sig_s, fp_s, fn_s, rfd_s, pin_s, e1_s;
  logic [13:0] raw_in;
  logic [13:0] meta_q;
  logic [13:0] sync_q;

  edge_sync u_rx_clk
  (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_async(I_RX_CLOCK_IN),
    .o_level(rx_clk_s),
    .o_rise(rx_clk_rise),
    .o_fall()
  );

  edge_sync u_tx_clk
  (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_async(I_TX_CLOCK),
    .o_level(tx_clk_s),
    .o_rise(tx_clk_rise),
    .o_fall()
  );

  edge_sync u_ft_clk
  (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_async(I_FRAMER_TX_CLOCK_IN),
    .o_level(),
    .o_rise(ftc_rise),
    .o_fall()
  );

  assign raw_in = {I_RX_LINE_POS_IN, I_RX_LINE_NEG_IN, I_FRAMER_TX_POS_IN,
                   I_FRAMER_TX_NEG_IN, I_TX_FRAME_SYNC, I_RX_FRAME_SYNC,
                   I_TX_SERIAL_IN, I_TX_INSERT_IN, I_TX_SIGNALING_IN, I_FMT_POS,
                   I_FMT_NEG, I_RX_FRAMER_DATA, I_MUX_OR_POWERDOWN_PIN, I_E1_MODE};

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  assign {rxp_s, rxn_s, ftp_s, ftn_s, txs_s, rxs_s, ser_s, ins_s, sig_s, fp_s,
          fn_s, rfd_s, pin_s, e1_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB registers.
  logic [7:0] ctrl_q;
  logic [31:0] ch_en_q;
  logic [31:0] ch_active_q;
  logic apb_wr, apb_rd, addr_ok;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `ADDR_LOOP_CTRL) || (a == `ADDR_CH_EN_1) ||
               (a == `ADDR_CH_EN_2) || (a == `ADDR_CH_EN_3) ||
               (a == `ADDR_CH_EN_4) || (a == `ADDR_STATUS);
  endfunction

  assign addr_ok = addr_hit(I_PADDR);
  assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE && addr_ok;
  assign apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ctrl_q <= `RESET_BYTE;
      ch_en_q <= '0;
    end
    else if (apb_wr)
    begin
      // Unused bits 5 and 6 are not stored; software keeps them zero.
      if (I_PADDR == `ADDR_LOOP_CTRL)
      begin
        ctrl_q <= I_PWDATA[7:0] & `CTRL_WMASK;
      end
      // Register n bit k enables channel 8*(n-1)+k+1.
      if (I_PADDR == `ADDR_CH_EN_1)
      begin
        ch_en_q[7:0] <= I_PWDATA[7:0];
      end
      if (I_PADDR == `ADDR_CH_EN_2)
      begin
        ch_en_q[15:8] <= I_PWDATA[7:0];
      end
      if (I_PADDR == `ADDR_CH_EN_3)
      begin
        ch_en_q[23:16] <= I_PWDATA[7:0];
      end
      if (I_PADDR == `ADDR_CH_EN_4)
      begin
        ch_en_q[31:24] <= I_PWDATA[7:0];
      end
    end
  end

  logic [4:0] slot_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_PRDATA <= '0;
    end
    else if (apb_rd)
    begin
      case (I_PADDR)
        `ADDR_LOOP_CTRL: O_PRDATA <= {24'h000000, ctrl_q};
        `ADDR_CH_EN_1: O_PRDATA <= {24'h000000, ch_en_q[7:0]};
        `ADDR_CH_EN_2: O_PRDATA <= {24'h000000, ch_en_q[15:8]};
        `ADDR_CH_EN_3: O_PRDATA <= {24'h000000, ch_en_q[23:16]};
        `ADDR_CH_EN_4: O_PRDATA <= {24'h000000, ch_en_q[31:24]};
        `ADDR_STATUS: O_PRDATA <= {18'h00000, O_LINE_UNIT_CONNECTED, e1_s, slot_q,
                                   ch_active_q[slot_q], 6'h00};
        default: O_PRDATA <= '0;
      endcase
    end
  end

  logic framer_side_loop, payload_loop, remote_line_loop, local_line_loop, mux_bit, pin_sel;
  assign framer_side_loop = ctrl_q[`BIT_FRAMER_LOOP];
  assign payload_loop = ctrl_q[`BIT_PAYLOAD_LOOP];
  assign remote_line_loop = ctrl_q[`BIT_REMOTE_LOOP];
  assign local_line_loop = ctrl_q[`BIT_LOCAL_LOOP];
  assign mux_bit = ctrl_q[`BIT_MUX];
  assign pin_sel = ctrl_q[`BIT_PIN_SEL];

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin role and line unit connection.
  logic connected;
  assign O_TX_POWERDOWN = pin_sel && pin_s;
  assign connected = !mux_bit && (pin_sel || pin_s);
  assign O_LINE_UNIT_CONNECTED = connected;

  // When separated, the external framer-side pins feed the framer instead.
  logic line_p, line_n, line_tx_tick;
  assign line_p = connected ? rxp_s : ftp_s;
  assign line_n = connected ? rxn_s : ftn_s;
  assign line_tx_tick = connected ? tx_clk_rise : ftc_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Timing references.
  // Payload loop moves transmit timing onto the receive clock.
  assign O_TX_TIMING_TICK = payload_loop ? rx_clk_rise : line_tx_tick;
  assign O_TX_LINK_CLOCK = payload_loop ? rx_clk_s : tx_clk_s;
  // Framer loop retimes the receive side from the transmit clock.
  assign O_RX_TIMING_TICK = framer_side_loop ? tx_clk_rise : rx_clk_rise;
  // Payload loop forces channel clock and block low.
  assign O_TX_CHANNEL_CLOCK = payload_loop ? 1'b0 : tx_clk_s;
  assign O_TX_CHANNEL_BLOCK = payload_loop ? 1'b0 : |ch_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Slot counter on transmit frame; channel enables switch on boundaries.
  logic [2:0] bit_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      bit_q <= '0;
      slot_q <= '0;
      ch_active_q <= '0;
    end
    else if (tx_clk_rise)
    begin
      if (txs_s)
      begin
        bit_q <= '0;
        slot_q <= '0;
        ch_active_q <= ch_en_q;
      end
      else if ({1'b0, bit_q} == `BITS_PER_SLOT - 4'h1)
      begin
        bit_q <= '0;
        slot_q <= slot_q + 5'h01;
        ch_active_q <= ch_en_q;
      end
      else
      begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive data buffered for the per-channel substitution path.
  logic rxq_valid, rxq_ready, rxq_take, rx_buf_bit;
  logic [2:0] rxq_out;
  bit_fifo #(.WIDTH(3), .DEPTH(FIFO_DEPTH)) u_rx_fifo
  (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_valid(rx_clk_rise),
    .o_ready(rxq_ready),
    .i_data({rxs_s, rfd_s, 1'b0}),
    .o_valid(rxq_valid),
    .i_ready(rxq_take),
    .o_data(rxq_out)
  );
  // Drained one bit per transmit clock; clocks must already be tied.
  assign rxq_take = tx_clk_rise;
  assign rx_buf_bit = rxq_valid ? rxq_out[1] : rfd_s;

  // Any set of enabled channels takes receive data in place of serial.
  logic use_rx;
  assign use_rx = ch_active_q[slot_q];
  // Payload loop ignores backplane serial, insert and signaling.
  assign O_TX_SERIAL_TO_FMT = payload_loop ? rfd_s : (use_rx ? rx_buf_bit : ser_s);
  assign O_TX_INSERT_TO_FMT = payload_loop ? 1'b0 : ins_s;
  assign O_TX_SIGNALING_TO_FMT = payload_loop ? 1'b0 : sig_s;
  // Framer regenerates framing, CRC and overhead; payload only.
  assign O_REGEN_OVERHEAD = payload_loop;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit line source and receive path selection.
  tx_src_t src;
  always_comb
  begin
    if (remote_line_loop)
    begin
      src = TX_REMOTE;
    end
    else if (framer_side_loop && !e1_s)
    begin
      src = TX_ONES;
    end
    else if (payload_loop)
    begin
      src = TX_PAYLOAD;
    end
    else
    begin
      src = TX_NORMAL;
    end
  end

  // Unframed all-ones toggles marks between rails on each transmit tick.
  logic ones_pol_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ones_pol_q <= 1'b0;
      O_TX_LINE_POS_OUT <= 1'b0;
      O_TX_LINE_NEG_OUT <= 1'b0;
      O_RX_POS <= 1'b0;
      O_RX_NEG <= 1'b0;
      O_RX_JITTER_ATTEN_PATH <= 1'b0;
    end
    else
    begin
      if (O_TX_TIMING_TICK)
      begin
        ones_pol_q <= !ones_pol_q;
        case (src)
          TX_REMOTE:
          begin
            O_TX_LINE_POS_OUT <= line_p;
            O_TX_LINE_NEG_OUT <= line_n;
          end
          TX_ONES:
          begin
            O_TX_LINE_POS_OUT <= ones_pol_q;
            O_TX_LINE_NEG_OUT <= !ones_pol_q;
          end
          default:
          begin
            O_TX_LINE_POS_OUT <= fp_s;
            O_TX_LINE_NEG_OUT <= fn_s;
          end
        endcase
      end
      // Framer or local loop replaces line receive with transmit data.
      if (framer_side_loop || local_line_loop)
      begin
        O_RX_POS <= fp_s;
        O_RX_NEG <= fn_s;
      end
      else
      begin
        O_RX_POS <= line_p;
        O_RX_NEG <= line_n;
      end
      O_RX_JITTER_ATTEN_PATH <= local_line_loop;
    end
  end
endmodule

// *** test/loopback_props.sv ***
// Checker bound to loopback_ctrl; judges the loop modes from its ports alone.
// Assumes the register map and control bit places of the defines header.
`timescale 1ns/1ps
`include "loopback_defines.svh"
module loopback_props
(
  // Clock, reset and bus.
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Pins and outputs.
  input wire logic I_MUX_OR_POWERDOWN_PIN,
  input wire logic I_RX_CLOCK_IN,
  input wire logic I_TX_CLOCK,
  input wire logic O_RX_TIMING_TICK,
  input wire logic O_TX_TIMING_TICK,
  input wire logic O_RX_JITTER_ATTEN_PATH,
  input wire logic O_TX_CHANNEL_CLOCK,
  input wire logic O_TX_CHANNEL_BLOCK,
  input wire logic O_TX_POWERDOWN,
  input wire logic O_LINE_UNIT_CONNECTED
);
  logic [7:0] ctl_q;
  logic acc;
  assign acc = I_PSEL && I_PENABLE;
  // Shadow copy, since the checker cannot see the register itself.
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
      ctl_q <= 8'h00;
    else if (acc && I_PWRITE && I_PADDR == `ADDR_LOOP_CTRL)
      ctl_q <= I_PWDATA[7:0] & `CTRL_WMASK;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESETN);
  // Six quiet cycles cover the synchroniser and edge detect in flight.
  sequence tx_still;
    (ctl_q[`BIT_FRAMER_LOOP] && $stable(I_TX_CLOCK)) [*6];
  endsequence
  sequence rx_still;
    (ctl_q[`BIT_PAYLOAD_LOOP] && $stable(I_RX_CLOCK_IN)) [*6];
  endsequence
  ready_always_a:
    assert property (O_PREADY) else $error("Ready went low.");
  unmapped_err_a:
    assert property (acc && I_PADDR == `ADDR_MODE |-> O_PSLVERR) else $error("No bus error.");
  mapped_ok_a:
    assert property (acc && I_PADDR == `ADDR_CH_EN_2 |-> !O_PSLVERR) else $error("False error.");
  // The shared pin reaches the logic through two flip-flops, hence the two-cycle look back.
  connect_table_a:
    assert property ($past(I_RESETN, 2) |-> O_LINE_UNIT_CONNECTED ==
      (!ctl_q[`BIT_MUX] && (ctl_q[`BIT_PIN_SEL] || $past(I_MUX_OR_POWERDOWN_PIN, 2))))
    else $error("Bad connect state.");
  pin_role_a:
    assert property (!ctl_q[`BIT_PIN_SEL] |-> !O_TX_POWERDOWN) else $error("Bad power-down.");
  pin_drive_a:
    assert property ($past(I_RESETN, 2) && ctl_q[`BIT_PIN_SEL] |->
      O_TX_POWERDOWN == $past(I_MUX_OR_POWERDOWN_PIN, 2))
    else $error("Power-down does not follow pin.");
  chan_hold_a:
    assert property (ctl_q[`BIT_PAYLOAD_LOOP] |-> !O_TX_CHANNEL_CLOCK && !O_TX_CHANNEL_BLOCK)
    else $error("Channel outputs not held low.");
  tx_timing_a:
    assert property (rx_still |-> !O_TX_TIMING_TICK) else $error("Transmit tick not from rx.");
  rx_timing_a:
    assert property (tx_still |-> !O_RX_TIMING_TICK) else $error("Receive tick not from tx.");
  local_path_a:
    assert property ($stable(ctl_q[`BIT_LOCAL_LOOP]) |->
      O_RX_JITTER_ATTEN_PATH == ctl_q[`BIT_LOCAL_LOOP]) else $error("Bad jitter path.");
endmodule
bind loopback_ctrl loopback_props u_props
(
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_MUX_OR_POWERDOWN_PIN(I_MUX_OR_POWERDOWN_PIN),
  .I_RX_CLOCK_IN(I_RX_CLOCK_IN), .I_TX_CLOCK(I_TX_CLOCK), .O_RX_TIMING_TICK(O_RX_TIMING_TICK),
  .O_TX_TIMING_TICK(O_TX_TIMING_TICK), .O_RX_JITTER_ATTEN_PATH(O_RX_JITTER_ATTEN_PATH),
  .O_TX_CHANNEL_CLOCK(O_TX_CHANNEL_CLOCK), .O_TX_CHANNEL_BLOCK(O_TX_CHANNEL_BLOCK),
  .O_TX_POWERDOWN(O_TX_POWERDOWN), .O_LINE_UNIT_CONNECTED(O_LINE_UNIT_CONNECTED)
);

// *** test/line_far_end.sv ***
// Far-side model: line clocks and transmit formatter marks for loopback_ctrl.
// Assumes the bench gates each clock; a stopped clock rests low.
`timescale 1ns/1ps
module line_far_end
(
  // Run controls.
  input wire logic i_tx_run,
  input wire logic i_rx_run,
  // Clocks and formatter marks.
  output logic o_tx_clock,
  output logic o_rx_clock,
  output logic o_fmt_pos,
  output logic o_fmt_neg
);
  // Two separate generators with a phase offset, never tied together.
  initial
  begin
    o_tx_clock = 1'h0;
    o_rx_clock = 1'h0;
    o_fmt_pos = 1'h1;
    o_fmt_neg = 1'h0;
    fork
      forever #80 o_tx_clock = i_tx_run && !o_tx_clock;
      #37 forever #80 o_rx_clock = i_rx_run && !o_rx_clock;
    join
  end
  // Marks alternate in polarity, one per transmit bit.
  always @(posedge o_tx_clock)
  begin
    o_fmt_pos <= !o_fmt_pos;
    o_fmt_neg <= o_fmt_pos;
  end
endmodule

// *** test/tb_transceiver_loopback_control.sv ***
// Bench for loopback_ctrl: APB register tasks and loop-mode scenarios.
// Assumes line_far_end for the line clocks and the bound loopback_props checker.
`timescale 1ns/1ps
`include "loopback_defines.svh"
module tb_transceiver_loopback_control;
  logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic e1 = 1'h0, pin = 1'h0, rxp = 1'h0, rxn = 1'h0, txr = 1'h0, rxr = 1'h0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [8:0] sq = 9'h000;
  logic [7:0] pat [1:4] = '{8'h01, 8'h80, 8'h5A, 8'hFF};
  logic rdy, err, serr, txc, rxc, fp, fn, lp, ln, rt, tt, jit, chc, chb, pd, con;
  logic sto, ito, sgo, rgo, rxpo, rxno, lck;
  logic [8:0] sd1 = 9'h000, sd2 = 9'h000;
  int n_fail = 0;
  int compares = 0;
  int ct, cr, cl;
  always #10 clk = !clk;
  always @(posedge clk) sq <= sq + 9'h001;
  // Pin values as the logic sees them behind its two input flip-flops.
  always @(posedge clk)
  begin
    sd1 <= sq;
    sd2 <= sd1;
  end
  loopback_ctrl dut
  (
    .I_CLK_SYS(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(serr),
    .I_E1_MODE(e1), .I_MUX_OR_POWERDOWN_PIN(pin), .I_RX_LINE_POS_IN(rxp),
    .I_RX_LINE_NEG_IN(rxn), .I_RX_CLOCK_IN(rxc), .I_RX_FRAME_SYNC(sq[0]),
    .I_FRAMER_TX_POS_IN(sq[1]), .I_FRAMER_TX_NEG_IN(sq[2]), .I_FRAMER_TX_CLOCK_IN(sq[3]),
    .I_TX_CLOCK(txc), .I_TX_FRAME_SYNC(sq[4]), .I_TX_SERIAL_IN(sq[5]),
    .I_TX_INSERT_IN(sq[6]), .I_TX_SIGNALING_IN(sq[7]), .I_FMT_POS(fp), .I_FMT_NEG(fn),
    .I_RX_FRAMER_DATA(sq[8]), .O_TX_LINE_POS_OUT(lp), .O_TX_LINE_NEG_OUT(ln),
    .O_RX_POS(rxpo), .O_RX_NEG(rxno), .O_RX_TIMING_TICK(rt), .O_RX_JITTER_ATTEN_PATH(jit),
    .O_TX_TIMING_TICK(tt), .O_TX_LINK_CLOCK(lck), .O_TX_CHANNEL_CLOCK(chc),
    .O_TX_CHANNEL_BLOCK(chb), .O_TX_SERIAL_TO_FMT(sto), .O_TX_INSERT_TO_FMT(ito),
    .O_TX_SIGNALING_TO_FMT(sgo), .O_REGEN_OVERHEAD(rgo), .O_TX_POWERDOWN(pd),
    .O_LINE_UNIT_CONNECTED(con)
  );
  line_far_end far
  (
    .i_tx_run(txr), .i_rx_run(rxr), .o_tx_clock(txc), .o_rx_clock(rxc),
    .o_fmt_pos(fp), .o_fmt_neg(fn)
  );
  ////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  // Read data and error stand through the access phase, so both are taken at the ready edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
      @(posedge clk);
    while (rdy !== 1'h1);
    err = serr;
    rd = prd;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic ctl(input logic [7:0] v);
    xfer(1'h1, `ADDR_LOOP_CTRL, {24'h0, v});
  endtask
  task automatic watch(input int n);
    ct = 0;
    cr = 0;
    cl = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      ct += int'(tt === 1'h1);
      cr += int'(rt === 1'h1);
      cl += int'(lck === 1'h1);
    end
    @(posedge clk);
  endtask
  task automatic conclude;
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'h0, `ADDR_LOOP_CTRL + 12'(4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    ctl(8'h9F);
    xfer(1'h0, `ADDR_LOOP_CTRL, 32'h0);
    chk("control", rd, 32'h9F);
    // Channel enables are set only while both line clocks stand still.
    for (int i = 1; i < 5; i++)
      xfer(1'h1, `ADDR_LOOP_CTRL + 12'(4 * i), {24'h0, pat[i]});
    for (int i = 1; i < 5; i++)
    begin
      xfer(1'h0, `ADDR_LOOP_CTRL + 12'(4 * i), 32'h0);
      chk("channel enables", rd, {24'h0, pat[i]});
      xfer(1'h1, `ADDR_LOOP_CTRL + 12'(4 * i), 32'h0);
    end
    xfer(1'h1, `ADDR_MODE, 32'hFF);
    chk("unmapped error", {31'h0, err}, 32'h1);
    xfer(1'h0, `ADDR_MODE, 32'h0);
    chk("unmapped read", rd, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      pin <= k[1];
      ctl({k[2], 2'h0, k[0], 4'h0});
      chk("connected", {31'h0, con}, {31'h0, !k[0] && (k[2] || k[1])});
    end
    ctl(8'h02);
    rxr <= 1'h1;
    watch(100);
    chk("payload tx ticks", {31'h0, ct > 0}, 32'h1);
    chk("payload rx ticks", {31'h0, cr > 0}, 32'h1);
    chk("channel outputs", {30'h0, chc, chb}, 32'h0);
    chk("payload link clock", {31'h0, cl > 0}, 32'h1);
    chk("payload serial", {31'h0, sto}, {31'h0, sd2[8]});
    chk("payload insert signaling", {30'h0, ito, sgo}, 32'h0);
    chk("payload regenerate", {31'h0, rgo}, 32'h1);
    ctl(8'h00);
    watch(100);
    chk("normal tx ticks", ct, 32'h0);
    chk("normal link clock", cl, 32'h0);
    chk("backplane serial", {31'h0, sto}, {31'h0, sd2[5]});
    chk("normal regenerate", {31'h0, rgo}, 32'h0);
    xfer(1'h0, `ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h00002000);
    ctl(8'h01);
    watch(100);
    chk("framer rx ticks", cr, 32'h0);
    rxr <= 1'h0;
    txr <= 1'h1;
    watch(100);
    chk("framer rx ticks", {31'h0, cr > 0}, 32'h1);
    chk("ones mark", {31'h0, lp ^ ln}, 32'h1);
    chk("framer rx data", {31'h0, rxpo ^ rxno}, 32'h1);
    rxr <= 1'h1;
    rxp <= 1'h1;
    ctl(8'h04);
    watch(60);
    chk("remote echo", {30'h0, lp, ln}, 32'h2);
    rxp <= 1'h0;
    rxn <= 1'h1;
    watch(60);
    chk("remote echo", {30'h0, lp, ln}, 32'h1);
    rxn <= 1'h0;
    ctl(8'h08);
    watch(4);
    chk("jitter path", {31'h0, jit}, 32'h1);
    chk("local rx data", {31'h0, rxpo ^ rxno}, 32'h1);
    chk("local tx normal", {31'h0, lp ^ ln}, 32'h1);
    conclude();
  end
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
